// *** ppio_pkg.sv ***
package ppio_pkg;

   // ------------------------------------------------------------
   // Widths
   // ------------------------------------------------------------
   localparam int ADDR_W = 4;
   localparam int DATA_W = 8;
   localparam int P2_PINS = 5;
   localparam int P3_PINS = 8;

   typedef logic [ADDR_W-1:0] ppio_addr_t;
   typedef logic [DATA_W-1:0] ppio_byte_t;
   typedef logic [P2_PINS-1:0] ppio_p2_t;
   typedef logic [1:0] ppio_mode_t;

   // ------------------------------------------------------------
   // Register offsets
   // ------------------------------------------------------------
   localparam ppio_addr_t OFS_P3_DIR = 4'h0;
   localparam ppio_addr_t OFS_P3_LATCH = 4'h1;
   localparam ppio_addr_t OFS_P2_DIR = 4'h2;
   localparam ppio_addr_t OFS_P2_LATCH = 4'h3;
   localparam ppio_addr_t OFS_P2_PULLUP = 4'h4;
   localparam ppio_addr_t OFS_SYS_CTRL = 4'h5;
   localparam ppio_addr_t OFS_PWM_OE_B = 4'h6;
   localparam ppio_addr_t OFS_I2C_CTRL = 4'h7;

   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int SYS_IO_STROBE_SELECT_BIT = 0;
   localparam int SYS_EXTERNAL_EXPANSION_ENABLE_BIT = 1;
   localparam int I2C_EN_BIT = 0;
   localparam int SCL_PIN = 4;
   localparam int SDA_PIN = 3;

   // ------------------------------------------------------------
   // Reset values and mode codes
   // ------------------------------------------------------------
   localparam ppio_byte_t RST_BYTE = 8'h00;
   localparam ppio_p2_t RST_P2 = 5'h00;
   localparam ppio_mode_t MODE_EXPANDED = 2'h1;

endpackage

// *** ppio_p2_if.sv ***
`timescale 1ns/1ns
interface ppio_p2_if;
   logic mode1;
   logic exp_en;
   logic io_strobe_sel;
   logic i2c_en;
   logic scl_low;
   logic sda_low;
   logic [ppio_pkg::P2_PINS-1:0] dir;
   logic [ppio_pkg::P2_PINS-1:0] latch;
   logic [ppio_pkg::P2_PINS-1:0] pwm_en;
   logic [ppio_pkg::P2_PINS-1:0] addr;
   logic [ppio_pkg::P2_PINS-1:0] pwm;
   logic [ppio_pkg::P2_PINS-1:0] pin_out;
   logic [ppio_pkg::P2_PINS-1:0] pin_oe_n;
   logic [ppio_pkg::P2_PINS-1:0] pin_input;

   modport ctrl (
      output mode1, exp_en, io_strobe_sel, i2c_en, scl_low, sda_low,
      output dir, latch, pwm_en, addr, pwm,
      input pin_out, pin_oe_n, pin_input
   );
   modport mux (
      input mode1, exp_en, io_strobe_sel, i2c_en, scl_low, sda_low,
      input dir, latch, pwm_en, addr, pwm,
      output pin_out, pin_oe_n, pin_input
   );
endinterface

// *** ppio_p2mux.sv ***
`timescale 1ns/1ns
module ppio_p2mux (
   ppio_p2_if.mux p2
);
   import ppio_pkg::*;

   // ------------------------------------------------------------
   // Per-pin function select
   // ------------------------------------------------------------
   // Returns {drive, value}; mode 1 ignores direction entirely
   function automatic logic [1:0] pin_sel(
      input logic mode1,
      input logic exp_en,
      input logic dir,
      input logic pwm_en,
      input logic strobe_port,
      input logic addr,
      input logic pwm,
      input logic latch
   );
      if (mode1) begin
         return {1'h1, addr};
      end
      if (!dir) begin
         return 2'h0;
      end
      if (pwm_en) begin
         return {1'h1, pwm};
      end
      if (exp_en && !strobe_port) begin
         return {1'h1, addr};
      end
      return {1'h1, latch};
   endfunction

   // ------------------------------------------------------------
   // Pin muxing
   // ------------------------------------------------------------
   for (genvar i = 0; i < P2_PINS; i++) begin : g_pin
      localparam bit IS_I2C = (i == SCL_PIN) || (i == SDA_PIN);
      logic [1:0] sel;
      logic own_i2c;
      logic i2c_low;
      // Only pin 4 honours the strobe-select bit
      assign sel = pin_sel(p2.mode1, p2.exp_en, p2.dir[i], p2.pwm_en[i],
                           (i == SCL_PIN) ? p2.io_strobe_sel : 1'h0,
                           p2.addr[i], p2.pwm[i], p2.latch[i]);
      assign own_i2c = IS_I2C && !p2.mode1 && p2.i2c_en;
      assign i2c_low = (i == SCL_PIN) ? p2.scl_low : p2.sda_low;
      // Open drain while I2C owns the pin: only ever drive low, release otherwise; other pins drive sel[0]
      assign p2.pin_out[i] = own_i2c ? 1'h0 : sel[0];
      assign p2.pin_oe_n[i] = own_i2c ? ~i2c_low : ~sel[1];
      assign p2.pin_input[i] = ~own_i2c & ~sel[1];
   end

endmodule

// *** ppio_top.sv ***
// Added by the designer: the register addresses and the strobed register port.
`timescale 1ns/1ns
module ppio_top (
   input wire logic core_clk_i,
   input wire logic srst_i,
   input wire ppio_pkg::ppio_mode_t mode_i,
   input wire logic hw_standby_i,
   input wire ppio_pkg::ppio_addr_t reg_addr_i,
   input wire ppio_pkg::ppio_byte_t reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output ppio_pkg::ppio_byte_t reg_rdata_o,
   input wire ppio_pkg::ppio_p2_t p2_in_i,
   output ppio_pkg::ppio_p2_t p2_out_o,
   output ppio_pkg::ppio_p2_t p2_oe_n_o,
   output ppio_pkg::ppio_p2_t p2_pullup_o,
   input wire ppio_pkg::ppio_p2_t ext_addr_hi_i,
   input wire ppio_pkg::ppio_p2_t pwm_i,
   input wire logic i2c1_clock_line_low_i,
   input wire logic i2c1_data_line_low_i,
   output logic i2c1_clock_line_o,
   output logic i2c1_data_line_o,
   input wire ppio_pkg::ppio_byte_t p3_in_i,
   output ppio_pkg::ppio_byte_t p3_out_o,
   output ppio_pkg::ppio_byte_t p3_oe_n_o,
   input wire ppio_pkg::ppio_byte_t dbus_wdata_i,
   input wire logic dbus_drive_i,
   output ppio_pkg::ppio_byte_t dbus_rdata_o
);
   import ppio_pkg::*;

   // ------------------------------------------------------------
   // Decode helpers
   // ------------------------------------------------------------
   // Latched bits where output, live pin where input
   function automatic ppio_byte_t port_read(
      input ppio_byte_t latch,
      input ppio_byte_t dir,
      input ppio_byte_t pins
   );
      return (latch & dir) | (pins & ~dir);
   endfunction

   function automatic logic wr_hit(
      input logic wr,
      input ppio_addr_t addr,
      input ppio_addr_t ofs
   );
      return wr && (addr == ofs);
   endfunction

   // ------------------------------------------------------------
   // Register state
   // ------------------------------------------------------------
   ppio_byte_t p3_dir_ff;
   ppio_byte_t p3_latch_ff;
   ppio_p2_t p2_dir_ff;
   ppio_p2_t p2_latch_ff;
   ppio_p2_t p2_pullup_ctl_ff;
   ppio_p2_t pwm_oe_ff;
   logic exp_en_ff;
   logic io_strobe_select_ff;
   logic i2c_en_ff;
   ppio_byte_t rdata_ff;
   ppio_byte_t nxt_rdata;

   logic mode1;
   logic p3_bus_mode;

   ppio_p2_if p2_bus ();

   assign mode1 = (mode_i == MODE_EXPANDED);

   // port-3 direction bits
   // Write-only register, cleared by reset
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         p3_dir_ff <= RST_BYTE;
      end else if (wr_hit(reg_wr_i, reg_addr_i, OFS_P3_DIR)) begin
         p3_dir_ff <= reg_wdata_i;
      end
   end

   // port-3 output latch
   // Written in every mode, so software can preload before leaving bus mode
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         p3_latch_ff <= RST_BYTE;
      end else if (wr_hit(reg_wr_i, reg_addr_i, OFS_P3_LATCH)) begin
         p3_latch_ff <= reg_wdata_i;
      end
   end

   // Port-2 direction, latch and pull-up control
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         p2_dir_ff <= RST_P2;
         p2_latch_ff <= RST_P2;
         p2_pullup_ctl_ff <= RST_P2;
      end else begin
         if (wr_hit(reg_wr_i, reg_addr_i, OFS_P2_DIR)) begin
            p2_dir_ff <= reg_wdata_i[P2_PINS-1:0];
         end
         if (wr_hit(reg_wr_i, reg_addr_i, OFS_P2_LATCH)) begin
            p2_latch_ff <= reg_wdata_i[P2_PINS-1:0];
         end
         if (wr_hit(reg_wr_i, reg_addr_i, OFS_P2_PULLUP)) begin
            p2_pullup_ctl_ff <= reg_wdata_i[P2_PINS-1:0];
         end
      end
   end

   // System, PWM enable and I2C enable bits
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         exp_en_ff <= 1'h0;
         io_strobe_select_ff <= 1'h0;
         pwm_oe_ff <= RST_P2;
         i2c_en_ff <= 1'h0;
      end else begin
         if (wr_hit(reg_wr_i, reg_addr_i, OFS_SYS_CTRL)) begin
            exp_en_ff <= reg_wdata_i[SYS_EXTERNAL_EXPANSION_ENABLE_BIT];
            io_strobe_select_ff <= reg_wdata_i[SYS_IO_STROBE_SELECT_BIT];
         end
         if (wr_hit(reg_wr_i, reg_addr_i, OFS_PWM_OE_B)) begin
            pwm_oe_ff <= reg_wdata_i[P2_PINS-1:0];
         end
         if (wr_hit(reg_wr_i, reg_addr_i, OFS_I2C_CTRL)) begin
            i2c_en_ff <= reg_wdata_i[I2C_EN_BIT];
         end
      end
   end

   // ------------------------------------------------------------
   // Register read path
   // ------------------------------------------------------------
   // Write-only and unmapped addresses read as zero
   always_comb begin
      nxt_rdata = RST_BYTE;
      case (reg_addr_i)
         OFS_P3_LATCH: nxt_rdata = port_read(p3_latch_ff, p3_dir_ff, p3_in_i);
         OFS_P2_LATCH: nxt_rdata = port_read({3'h0, p2_latch_ff}, {3'h0, p2_dir_ff},
                                             {3'h0, p2_in_i});
         OFS_P2_PULLUP: nxt_rdata = {3'h0, p2_pullup_ctl_ff};
         OFS_SYS_CTRL: nxt_rdata = {6'h00, exp_en_ff, io_strobe_select_ff};
         OFS_PWM_OE_B: nxt_rdata = {3'h0, pwm_oe_ff};
         OFS_I2C_CTRL: nxt_rdata = {7'h00, i2c_en_ff};
         default: nxt_rdata = RST_BYTE;
      endcase
   end

   // Data valid only in the cycle after the strobe
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         rdata_ff <= RST_BYTE;
      end else begin
         rdata_ff <= reg_rd_i ? nxt_rdata : RST_BYTE;
      end
   end

   assign reg_rdata_o = rdata_ff;

   // ------------------------------------------------------------
   // Port 2 pin functions
   // ------------------------------------------------------------
   // mode flag to mux
   assign p2_bus.mode1 = mode1;
   assign p2_bus.exp_en = exp_en_ff;
   assign p2_bus.io_strobe_sel = io_strobe_select_ff;
   assign p2_bus.i2c_en = i2c_en_ff;
   assign p2_bus.scl_low = i2c1_clock_line_low_i;
   assign p2_bus.sda_low = i2c1_data_line_low_i;
   assign p2_bus.dir = p2_dir_ff;
   assign p2_bus.latch = p2_latch_ff;
   assign p2_bus.pwm_en = pwm_oe_ff;
   assign p2_bus.addr = ext_addr_hi_i;
   assign p2_bus.pwm = pwm_i;

   ppio_p2mux u_p2mux (
      .p2(p2_bus)
   );

   assign p2_out_o = p2_bus.pin_out;
   assign p2_oe_n_o = p2_bus.pin_oe_n;
   // I2C core always sees the wire level
   assign i2c1_clock_line_o = p2_in_i[SCL_PIN];
   assign i2c1_data_line_o = p2_in_i[SDA_PIN];

   // off in reset and standby
   // Software standby keeps the pull-ups, so it needs no input here
   assign p2_pullup_o = (mode1 || srst_i || hw_standby_i) ? RST_P2 :
                        (p2_bus.pin_input & ~p2_dir_ff & p2_pullup_ctl_ff);

   // ------------------------------------------------------------
   // Port 3 pins
   // ------------------------------------------------------------
   // port or data bus
   assign p3_bus_mode = mode1 || exp_en_ff;

   assign p3_out_o = p3_bus_mode ? dbus_wdata_i : p3_latch_ff;
   assign p3_oe_n_o = p3_bus_mode ? {P3_PINS{~dbus_drive_i}} : ~p3_dir_ff;
   assign dbus_rdata_o = p3_in_i;

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   a_mode1_address_out:
   assert property (@(posedge core_clk_i) disable iff (srst_i)
      mode1 |-> (p2_oe_n_o == RST_P2) && (p2_out_o == ext_addr_hi_i))
   else $error("mode 1 address not on port 2");

   a_scl_open_drain:
   assert property (@(posedge core_clk_i) disable iff (srst_i)
      (!mode1 && i2c_en_ff) |->
      !p2_out_o[SCL_PIN] && (p2_oe_n_o[SCL_PIN] == !i2c1_clock_line_low_i))
   else $error("clock pin not owned by I2C");

   a_sda_open_drain:
   assert property (@(posedge core_clk_i) disable iff (srst_i)
      (!mode1 && i2c_en_ff) |->
      !p2_out_o[SDA_PIN] && (p2_oe_n_o[SDA_PIN] == !i2c1_data_line_low_i))
   else $error("data pin not owned by I2C");

   a_pin4_strobe_sel:
   assert property (@(posedge core_clk_i) disable iff (srst_i)
      (!mode1 && exp_en_ff && !i2c_en_ff && p2_dir_ff[SCL_PIN] && !pwm_oe_ff[SCL_PIN])
      |-> !p2_oe_n_o[SCL_PIN] && (p2_out_o[SCL_PIN] ==
          (io_strobe_select_ff ? p2_latch_ff[SCL_PIN] : ext_addr_hi_i[SCL_PIN])))
   else $error("pin 4 strobe select wrong");

   a_pin3_pwm_sel:
   assert property (@(posedge core_clk_i) disable iff (srst_i)
      (!mode1 && exp_en_ff && !i2c_en_ff && p2_dir_ff[SDA_PIN]) |->
      p2_out_o[SDA_PIN] == (pwm_oe_ff[SDA_PIN] ? pwm_i[SDA_PIN] : ext_addr_hi_i[SDA_PIN]))
   else $error("pin 3 function wrong");

   a_low_pins_input:
   assert property (@(posedge core_clk_i) disable iff (srst_i)
      (!mode1 && exp_en_ff) |-> (p2_oe_n_o[0] == !p2_dir_ff[0]) &&
      (!p2_dir_ff[0] || (p2_out_o[0] == (pwm_oe_ff[0] ? pwm_i[0] : ext_addr_hi_i[0]))))
   else $error("pin 0 expanded function wrong");

   a_single_chip_port:
   assert property (@(posedge core_clk_i) disable iff (srst_i)
      (!mode1 && !exp_en_ff && p2_dir_ff[0] && !pwm_oe_ff[0]) |->
      !p2_oe_n_o[0] && (p2_out_o[0] == p2_latch_ff[0]))
   else $error("pin 0 not port output");

   a_pullup_mode1_off:
   assert property (@(posedge core_clk_i) disable iff (srst_i)
      mode1 |-> p2_pullup_o == RST_P2)
   else $error("pull-up on in mode 1");

   a_pullup_input_only:
   assert property (@(posedge core_clk_i) disable iff (srst_i)
      (p2_pullup_o != RST_P2) |->
      ((p2_pullup_o & (p2_dir_ff | ~p2_pullup_ctl_ff | ~p2_oe_n_o)) == RST_P2))
   else $error("pull-up on a non-input pin");

   a_pullup_standby_off:
   assert property (@(posedge core_clk_i) disable iff (srst_i)
      hw_standby_i |-> p2_pullup_o == RST_P2)
   else $error("pull-up on in hardware standby");

   a_p3dir_reset_clear:
   assert property (@(posedge core_clk_i) disable iff (srst_i)
      $past(srst_i) |-> (p3_dir_ff == RST_BYTE) && (p3_latch_ff == RST_BYTE))
   else $error("port 3 registers not cleared");

   a_p3_bus_mode:
   assert property (@(posedge core_clk_i) disable iff (srst_i)
      p3_bus_mode |-> (p3_out_o == dbus_wdata_i) && (p3_oe_n_o == {P3_PINS{~dbus_drive_i}}))
   else $error("port 3 not on data bus");

   a_p3_port_drive:
   assert property (@(posedge core_clk_i) disable iff (srst_i)
      !p3_bus_mode |-> (p3_oe_n_o == ~p3_dir_ff) && (p3_out_o == p3_latch_ff))
   else $error("port 3 single-chip drive wrong");

   a_p3_latch_write:
   assert property (@(posedge core_clk_i) disable iff (srst_i)
      (reg_wr_i && reg_addr_i == OFS_P3_LATCH) |=> p3_latch_ff == $past(reg_wdata_i))
   else $error("port 3 latch write lost");

   a_p3_read_latch:
   assert property (@(posedge core_clk_i) disable iff (srst_i)
      (reg_rd_i && reg_addr_i == OFS_P3_LATCH) |=>
      ((reg_rdata_o & $past(p3_dir_ff)) == ($past(p3_latch_ff) & $past(p3_dir_ff))))
   else $error("port 3 read misses latch");

   a_p3_read_pins:
   assert property (@(posedge core_clk_i) disable iff (srst_i)
      (reg_rd_i && reg_addr_i == OFS_P3_LATCH) |=>
      ((reg_rdata_o & ~$past(p3_dir_ff)) == ($past(p3_in_i) & ~$past(p3_dir_ff))))
   else $error("port 3 read misses pin level");

endmodule

// *** ppio_pins_model.sv ***
`timescale 1ns/1ns
// ------------------------------------------------------------
// Pin-side model: outside parts hanging on port 2 and port 3
// ------------------------------------------------------------
module ppio_pins_model (
   input wire logic core_clk_i,
   input wire ppio_pkg::ppio_p2_t p2_out_i,
   input wire ppio_pkg::ppio_p2_t p2_oe_n_i,
   input wire ppio_pkg::ppio_p2_t p2_pullup_i,
   input wire ppio_pkg::ppio_p2_t ext_p2_i,
   input wire ppio_pkg::ppio_p2_t ext_p2_en_i,
   input wire ppio_pkg::ppio_byte_t p3_out_i,
   input wire ppio_pkg::ppio_byte_t p3_oe_n_i,
   input wire ppio_pkg::ppio_byte_t ext_p3_i,
   input wire ppio_pkg::ppio_byte_t ext_p3_en_i,
   output ppio_pkg::ppio_p2_t p2_in_o,
   output ppio_pkg::ppio_byte_t p3_in_o
);
   import ppio_pkg::*;
   ppio_p2_t p2_last_ff;
   ppio_byte_t p3_last_ff;

   // Last level kept, so a floating line flips instead of looking stable
   always_ff @(posedge core_clk_i) begin
      p2_last_ff <= p2_in_o;
      p3_last_ff <= p3_in_o;
   end

   // Wire level: chip drive wins, then outside driver, then pull-up
   always_comb begin
      for (int i = 0; i < P2_PINS; i++) begin
         if (!p2_oe_n_i[i]) p2_in_o[i] = p2_out_i[i];
         else if (ext_p2_en_i[i]) p2_in_o[i] = ext_p2_i[i];
         else if (p2_pullup_i[i]) p2_in_o[i] = 1'h1;
         else p2_in_o[i] = ~p2_last_ff[i];
      end
      p3_in_o = (~p3_oe_n_i & p3_out_i) | (p3_oe_n_i & ext_p3_en_i & ext_p3_i)
         | (p3_oe_n_i & ~ext_p3_en_i & ~p3_last_ff);
   end
endmodule

// *** testbench.sv ***
`timescale 1ns/1ns
module testbench;
   import ppio_pkg::*;
   logic core_clk_i = 1'h0;
   logic srst_i = 1'h1;
   ppio_mode_t mode_i = 2'h0;
   logic hw_standby_i = 1'h0;
   ppio_addr_t reg_addr_i = 4'h0;
   ppio_byte_t reg_wdata_i = 8'h00;
   logic reg_wr_i = 1'h0;
   logic reg_rd_i = 1'h0;
   ppio_byte_t reg_rdata_o;
   ppio_p2_t p2_in_i, p2_out_o, p2_oe_n_o, p2_pullup_o;
   ppio_p2_t ext_addr_hi_i = 5'h00;
   ppio_p2_t pwm_i = 5'h00;
   ppio_p2_t ext2 = 5'h00;
   logic i2c1_clock_line_low_i = 1'h0;
   logic i2c1_data_line_low_i = 1'h0;
   logic i2c1_clock_line_o, i2c1_data_line_o;
   ppio_byte_t p3_in_i, p3_out_o, p3_oe_n_o, dbus_rdata_o;
   ppio_byte_t dbus_wdata_i = 8'h00;
   ppio_byte_t ext3 = 8'h00;
   logic dbus_drive_i = 1'h0;
   // Software view of the control registers
   ppio_byte_t p3d = 8'h00, p3l = 8'h00, e3_rd, e2_rd;
   ppio_p2_t p2d = 5'h00, p2l = 5'h00, p2u = 5'h00, pwe = 5'h00;
   logic io_strobe_select = 1'h0, external_expansion_enable = 1'h0, i2c_channel_enable = 1'h0;
   logic [31:0] seed = 32'hD1F34C8E;
   ppio_byte_t exp_q[$];
   logic rd_seen_ff = 1'h0;
   int bad_count = 0;
   int num_checks = 0;

   always #2 core_clk_i = ~core_clk_i;

   ppio_top dut (.core_clk_i(core_clk_i), .srst_i(srst_i), .mode_i(mode_i),
      .hw_standby_i(hw_standby_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
      .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
      .p2_in_i(p2_in_i), .p2_out_o(p2_out_o), .p2_oe_n_o(p2_oe_n_o),
      .p2_pullup_o(p2_pullup_o), .ext_addr_hi_i(ext_addr_hi_i), .pwm_i(pwm_i),
      .i2c1_clock_line_low_i(i2c1_clock_line_low_i),
      .i2c1_data_line_low_i(i2c1_data_line_low_i),
      .i2c1_clock_line_o(i2c1_clock_line_o), .i2c1_data_line_o(i2c1_data_line_o),
      .p3_in_i(p3_in_i), .p3_out_o(p3_out_o), .p3_oe_n_o(p3_oe_n_o),
      .dbus_wdata_i(dbus_wdata_i), .dbus_drive_i(dbus_drive_i), .dbus_rdata_o(dbus_rdata_o));

   // Outside drivers always on, so every undriven pin has a known level
   ppio_pins_model pins (.core_clk_i(core_clk_i), .p2_out_i(p2_out_o), .p2_oe_n_i(p2_oe_n_o),
      .p2_pullup_i(p2_pullup_o), .ext_p2_i(ext2), .ext_p2_en_i(5'h1F), .p3_out_i(p3_out_o),
      .p3_oe_n_i(p3_oe_n_o), .ext_p3_i(ext3), .ext_p3_en_i(8'hFF), .p2_in_o(p2_in_i),
      .p3_in_o(p3_in_i));

   function automatic logic [31:0] nxt();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic report_and_stop();
      if (bad_count == 0 && num_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // ------------------------------------------------------------
   // Register bus master, one gap cycle between strobes
   // ------------------------------------------------------------
   task automatic wr(input ppio_addr_t a, input ppio_byte_t d);
      @(posedge core_clk_i);
      reg_wr_i <= 1'h1;
      reg_addr_i <= a;
      reg_wdata_i <= d;
      @(posedge core_clk_i);
      reg_wr_i <= 1'h0;
   endtask

   task automatic rd(input ppio_addr_t a, input ppio_byte_t e);
      @(posedge core_clk_i);
      reg_rd_i <= 1'h1;
      reg_addr_i <= a;
      exp_q.push_back(e);
      @(posedge core_clk_i);
      reg_rd_i <= 1'h0;
   endtask

   // Read data stand only in the cycle after the strobe
   always @(posedge core_clk_i) rd_seen_ff <= reg_rd_i;
   always @(negedge core_clk_i) begin
      if (rd_seen_ff === 1'h1) begin
         if (exp_q.size() == 0) chk("read queue", 8'h01, 8'h00);
         else chk("reg_rdata_o", reg_rdata_o, exp_q.pop_front());
      end
   end

   // Pin expectations worked out from the selection priorities
   task automatic chk_pins();
      ppio_p2_t eo, eoe, epu, pin2;
      ppio_byte_t pin3;
      logic bus;
      @(negedge core_clk_i);
      for (int i = 0; i < P2_PINS; i++) begin
         eo[i] = 1'h0;
         eoe[i] = 1'h0;
         epu[i] = 1'h0;
         if (mode_i == MODE_EXPANDED) begin
            eo[i] = ext_addr_hi_i[i];
         end else if (i2c_channel_enable && (i == SCL_PIN || i == SDA_PIN)) begin
            eoe[i] = (i == SCL_PIN) ? !i2c1_clock_line_low_i : !i2c1_data_line_low_i;
         end else if (!p2d[i]) begin
            eoe[i] = 1'h1;
            epu[i] = p2u[i] & !hw_standby_i;
         end else if (pwe[i]) begin
            eo[i] = pwm_i[i];
         end else if (external_expansion_enable && (i != SCL_PIN || !io_strobe_select)) begin
            eo[i] = ext_addr_hi_i[i];
         end else begin
            eo[i] = p2l[i];
         end
      end
      pin2 = (~eoe & eo) | (eoe & ext2);
      e2_rd = {3'h0, (p2l & p2d) | (pin2 & ~p2d)};
      bus = (mode_i == MODE_EXPANDED) || external_expansion_enable;
      pin3 = bus ? (dbus_drive_i ? dbus_wdata_i : ext3) : ((p3l & p3d) | (ext3 & ~p3d));
      e3_rd = (p3l & p3d) | (pin3 & ~p3d);
      chk("p2_out_o", {3'h0, p2_out_o}, {3'h0, eo});
      chk("p2_oe_n_o", {3'h0, p2_oe_n_o}, {3'h0, eoe});
      chk("p2_pullup_o", {3'h0, p2_pullup_o}, {3'h0, epu});
      chk("i2c lines", {6'h00, i2c1_clock_line_o, i2c1_data_line_o}, {6'h00, pin2[4:3]});
      chk("p3_out_o", p3_out_o, bus ? dbus_wdata_i : p3l);
      chk("p3_oe_n_o", p3_oe_n_o, bus ? ~{8{dbus_drive_i}} : ~p3d);
      chk("dbus_rdata_o", dbus_rdata_o, pin3);
   endtask

   // Hang guard: the run needs a few thousand cycles at most
   initial begin
      #100000;
      bad_count++;
      report_and_stop();
   end

   initial begin
      logic [31:0] r;
      repeat (3) @(posedge core_clk_i);
      srst_i <= 1'h0;
      // Reset values, write-only and unmapped places
      rd(OFS_P3_DIR, 8'h00);
      rd(OFS_P2_DIR, 8'h00);
      wr(4'hF, 8'hA5);
      rd(4'hF, 8'h00);
      wr(OFS_P3_DIR, 8'hFF);
      p3d = 8'hFF;
      rd(OFS_P3_LATCH, 8'h00);
      // Random selections across all modes
      for (int n = 0; n < 60; n++) begin
         r = nxt();
         mode_i <= r[1:0];
         hw_standby_i <= r[2];
         io_strobe_select = r[3];
         external_expansion_enable = r[4];
         i2c_channel_enable = r[5];
         i2c1_clock_line_low_i <= r[6];
         i2c1_data_line_low_i <= r[7];
         dbus_drive_i <= r[8];
         p3d = r[23:16];
         p3l = r[31:24];
         r = nxt();
         dbus_wdata_i <= r[7:0];
         ext3 <= r[15:8];
         p2d = r[20:16];
         p2l = r[25:21];
         r = nxt();
         p2u = r[4:0];
         pwe = r[9:5];
         ext_addr_hi_i <= r[14:10];
         pwm_i <= r[19:15];
         ext2 <= r[24:20];
         wr(OFS_P3_DIR, p3d);
         wr(OFS_P3_LATCH, p3l);
         wr(OFS_P2_DIR, {3'h0, p2d});
         wr(OFS_P2_LATCH, {3'h0, p2l});
         wr(OFS_P2_PULLUP, {3'h0, p2u});
         wr(OFS_SYS_CTRL, {6'h00, external_expansion_enable, io_strobe_select});
         wr(OFS_PWM_OE_B, {3'h0, pwe});
         wr(OFS_I2C_CTRL, {7'h00, i2c_channel_enable});
         chk_pins();
         rd(OFS_P3_LATCH, e3_rd);
         rd(OFS_P2_LATCH, e2_rd);
      end
      // Reset in mid-run with pull-ups and directions armed
      wr(OFS_P2_PULLUP, 8'h1F);
      wr(OFS_P2_DIR, 8'h00);
      wr(OFS_P3_DIR, 8'hFF);
      wr(OFS_SYS_CTRL, 8'h00);
      wr(OFS_I2C_CTRL, 8'h00);
      @(posedge core_clk_i);
      mode_i <= 2'h0;
      hw_standby_i <= 1'h0;
      srst_i <= 1'h1;
      @(negedge core_clk_i);
      chk("p2_pullup_o", {3'h0, p2_pullup_o}, 8'h00);
      repeat (3) @(posedge core_clk_i);
      srst_i <= 1'h0;
      @(negedge core_clk_i);
      chk("p3_oe_n_o", p3_oe_n_o, 8'hFF);
      chk("p2_oe_n_o", {3'h0, p2_oe_n_o}, 8'h1F);
      repeat (2) @(posedge core_clk_i);
      report_and_stop();
   end
endmodule
